/* hdl/alarm_status_pkg.sv */
package alarm_status_pkg;
    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam logic [7:0] SLOW_ALARM_ADDR  = 8'h71;
    localparam logic [7:0] FAST_ALARM_ADDR  = 8'h72;
    localparam logic [7:0] RX_BIAS_ADDR     = 8'h73;
    localparam logic [7:0] WARN_ADDR        = 8'h74;
    localparam logic [7:0] ZERO_BYTE        = 8'h00;
    localparam logic [7:0] WARN_RESET       = 8'h10;

    // Valid bits of each register; everything else is reserved and reads 0, except the summary at bit 0 of the slow alarm register
    localparam logic [7:0] SLOW_ALARM_MASK  = 8'hF0;
    localparam logic [7:0] FAST_ALARM_MASK  = 8'h0B;
    localparam logic [7:0] RX_BIAS_MASK     = 8'hC8;
    localparam logic [7:0] WARN_MASK        = 8'hFF;

    // Bit positions
    localparam int SUMMARY_BIT   = 0;
    localparam int HIGH_BIAS_FAST_ALARM_BIT      = 3;
    localparam int TX_POWER_HIGH_FAST_ALARM_BIT    = 1;
    localparam int TX_POWER_LOW_FAST_ALARM_BIT    = 0;
    localparam int RX_HI_BIT     = 7;
    localparam int RX_LO_BIT     = 6;
    localparam int CEIL_BIT      = 3;
    localparam int SUPPLY_LO_BIT = 4;

    // Slow measurement channels: temperature, supply, monitor inputs 1..4
    localparam int MEAS_CH      = 6;
    localparam int TEMP_IDX     = 0;
    localparam int SUPPLY_IDX   = 1;
    localparam int MONITOR_INPUT_3_IDX     = 4;
    localparam int MONITOR_INPUT_4_IDX     = 5;
    localparam int MEAS_W       = 16;
    localparam int BIAS_W       = 9;
    localparam int OTHER_W      = 16;
endpackage

/* hdl/threshold_flag_cell.sv */
`timescale 1ns/1ps
`default_nettype none

// High/low comparison flags for one slow measurement channel
module threshold_flag_cell #(
    parameter logic LO_RESET = 1'b0
) (
    input  wire logic                                  clk_i,
    input  wire logic                                  reset_n_i,
    input  wire logic                                  sample_i,
    input  wire logic [alarm_status_pkg::MEAS_W-1:0]   value_i,
    input  wire logic [alarm_status_pkg::MEAS_W-1:0]   hi_thr_i,
    input  wire logic [alarm_status_pkg::MEAS_W-1:0]   lo_thr_i,
    input  wire logic                                  force_lo_i,
    output logic                                       hi_flag_o,
    output logic                                       lo_flag_o
);
    logic hi_reg;
    logic hi_next;
    logic lo_reg;
    logic lo_next;

    // Flags follow only completed conversions; forced low wins over a sample
    always_comb begin
        hi_next = hi_reg;
        lo_next = lo_reg;
        if (sample_i) begin
            hi_next = (value_i > hi_thr_i);
            lo_next = (value_i < lo_thr_i);
        end
        if (force_lo_i) begin
            lo_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            hi_reg <= 1'b0;
            lo_reg <= LO_RESET;
        end else begin
            hi_reg <= hi_next;
            lo_reg <= lo_next;
        end
    end

    assign hi_flag_o = hi_reg;
    assign lo_flag_o = lo_reg;
endmodule // threshold_flag_cell

`default_nettype wire

/* hdl/alarm_warning_status_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module alarm_warning_status_bank (
    input  wire logic                                   clk_i,
    input  wire logic                                   reset_n_i,
    // Register access port
    input  wire logic [7:0]                             addr_i,
    input  wire logic                                   rd_en_i,
    input  wire logic                                   wr_en_i,
    input  wire logic [7:0]                             wr_data_i,
    output logic      [7:0]                             rd_data_o,
    output logic                                        rd_valid_o,
    // Slow conversions
    input  wire logic [alarm_status_pkg::MEAS_CH-1:0]   meas_done_i,
    input  wire logic [alarm_status_pkg::MEAS_CH-1:0][alarm_status_pkg::MEAS_W-1:0] meas_value_i,
    input  wire logic [alarm_status_pkg::MEAS_CH-1:0][alarm_status_pkg::MEAS_W-1:0] hi_thr_i,
    input  wire logic [alarm_status_pkg::MEAS_CH-1:0][alarm_status_pkg::MEAS_W-1:0] lo_thr_i,
    input  wire logic                                   power_on_analog_trip_i,
    // Fast comparisons
    input  wire logic                                   fast_sample_i,
    input  wire logic                                   bias_high_cmp_i,
    input  wire logic                                   tx_power_high_cmp_i,
    input  wire logic                                   tx_power_low_cmp_i,
    input  wire logic                                   rx_level_high_cmp_i,
    input  wire logic                                   rx_level_low_cmp_i,
    input  wire logic [alarm_status_pkg::BIAS_W-1:0]    bias_request_i,
    input  wire logic [alarm_status_pkg::BIAS_W-1:0]    bias_ceiling_limit_i,
    // Transmit-disable sources
    input  wire logic                                   tx_disable_pin_i,
    input  wire logic                                   tx_disable_soft_bit_i,
    // Enables, laid out as the status registers they gate
    input  wire logic [7:0]                             slow_alarm_enable_i,
    input  wire logic [7:0]                             fast_alarm_enable_i,
    input  wire logic [7:0]                             rx_bias_enable_i,
    input  wire logic [7:0]                             warn_enable_i,
    input  wire logic [alarm_status_pkg::OTHER_W-1:0]   other_flags_i,
    input  wire logic [alarm_status_pkg::OTHER_W-1:0]   other_enable_i,
    output logic                                        tx_fault_irq_summary_o
);
    // ****************************************************************
    // Slow measurement flags
    // ****************************************************************
    logic [alarm_status_pkg::MEAS_CH-1:0] hi_flag;
    logic [alarm_status_pkg::MEAS_CH-1:0] lo_flag;

    // Only the supply channel has a forced low flag and a set reset value
    for (genvar g = 0; g < alarm_status_pkg::MEAS_CH; g++) begin : g_meas
        threshold_flag_cell #(
            .LO_RESET (1'(g == alarm_status_pkg::SUPPLY_IDX))
        ) u_cell (
            .clk_i      (clk_i),
            .reset_n_i  (reset_n_i),
            .sample_i   (meas_done_i[g]),
            .value_i    (meas_value_i[g]),
            .hi_thr_i   (hi_thr_i[g]),
            .lo_thr_i   (lo_thr_i[g]),
            .force_lo_i ((g == alarm_status_pkg::SUPPLY_IDX) && power_on_analog_trip_i),
            .hi_flag_o  (hi_flag[g]),
            .lo_flag_o  (lo_flag[g])
        );
    end

    // ****************************************************************
    // Fast comparison flags
    // ****************************************************************
    logic tx_disable;
    logic high_bias_fast_alarm_reg;
    logic high_bias_fast_alarm_next;
    logic tx_power_high_fast_alarm_reg;
    logic tx_power_high_fast_alarm_next;
    logic tx_power_low_fast_alarm_reg;
    logic tx_power_low_fast_alarm_next;
    logic rx_hi_reg;
    logic rx_hi_next;
    logic rx_lo_reg;
    logic rx_lo_next;
    logic ceil_reg;
    logic ceil_next;

    // Either source disables the transmitter
    assign tx_disable = tx_disable_pin_i | tx_disable_soft_bit_i;

    // Transmit-side flags are held clear while disabled: a comparison taken
    // with the laser off carries no meaning, so the clear wins here
    always_comb begin
        high_bias_fast_alarm_next   = high_bias_fast_alarm_reg;
        tx_power_high_fast_alarm_next = tx_power_high_fast_alarm_reg;
        tx_power_low_fast_alarm_next = tx_power_low_fast_alarm_reg;
        rx_hi_next  = rx_hi_reg;
        rx_lo_next  = rx_lo_reg;
        if (fast_sample_i) begin
            high_bias_fast_alarm_next   = bias_high_cmp_i;
            tx_power_high_fast_alarm_next = tx_power_high_cmp_i;
            tx_power_low_fast_alarm_next = tx_power_low_cmp_i;
            rx_hi_next  = rx_level_high_cmp_i;
            rx_lo_next  = rx_level_low_cmp_i;
        end
        ceil_next = (bias_request_i > bias_ceiling_limit_i);
        if (tx_disable) begin
            high_bias_fast_alarm_next   = 1'b0;
            tx_power_high_fast_alarm_next = 1'b0;
            tx_power_low_fast_alarm_next = 1'b0;
            ceil_next   = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            high_bias_fast_alarm_reg   <= 1'b0;
            tx_power_high_fast_alarm_reg <= 1'b0;
            tx_power_low_fast_alarm_reg <= 1'b0;
            rx_hi_reg  <= 1'b0;
            rx_lo_reg  <= 1'b0;
            ceil_reg   <= 1'b0;
        end else begin
            high_bias_fast_alarm_reg   <= high_bias_fast_alarm_next;
            tx_power_high_fast_alarm_reg <= tx_power_high_fast_alarm_next;
            tx_power_low_fast_alarm_reg <= tx_power_low_fast_alarm_next;
            rx_hi_reg  <= rx_hi_next;
            rx_lo_reg  <= rx_lo_next;
            ceil_reg   <= ceil_next;
        end
    end

    // ****************************************************************
    // Register images and fault summary
    // ****************************************************************
    logic [7:0] slow_alarm_img;
    logic [7:0] fast_alarm_img;
    logic [7:0] rx_bias_img;
    logic [7:0] warn_img;
    logic       summary_reg;
    logic       summary_next;
    logic       nonmask;

    // Reserved positions are tied to zero in every image
    always_comb begin
        slow_alarm_img = alarm_status_pkg::ZERO_BYTE;
        fast_alarm_img = alarm_status_pkg::ZERO_BYTE;
        rx_bias_img    = alarm_status_pkg::ZERO_BYTE;
        slow_alarm_img[7:4] = {hi_flag[alarm_status_pkg::MONITOR_INPUT_3_IDX],
                               lo_flag[alarm_status_pkg::MONITOR_INPUT_3_IDX],
                               hi_flag[alarm_status_pkg::MONITOR_INPUT_4_IDX],
                               lo_flag[alarm_status_pkg::MONITOR_INPUT_4_IDX]};
        slow_alarm_img[alarm_status_pkg::SUMMARY_BIT] = summary_reg;
        fast_alarm_img[alarm_status_pkg::HIGH_BIAS_FAST_ALARM_BIT]    = high_bias_fast_alarm_reg;
        fast_alarm_img[alarm_status_pkg::TX_POWER_HIGH_FAST_ALARM_BIT]  = tx_power_high_fast_alarm_reg;
        fast_alarm_img[alarm_status_pkg::TX_POWER_LOW_FAST_ALARM_BIT]  = tx_power_low_fast_alarm_reg;
        rx_bias_img[alarm_status_pkg::RX_HI_BIT]      = rx_hi_reg;
        rx_bias_img[alarm_status_pkg::RX_LO_BIT]      = rx_lo_reg;
        rx_bias_img[alarm_status_pkg::CEIL_BIT]       = ceil_reg;
        for (int i = 0; i < 4; i++) begin
            warn_img[7-2*i] = hi_flag[alarm_status_pkg::TEMP_IDX+i];
            warn_img[6-2*i] = lo_flag[alarm_status_pkg::TEMP_IDX+i];
        end
    end

    // Summary lags the flags by one cycle; the summary bit never gates itself
    always_comb begin
        nonmask = high_bias_fast_alarm_reg | tx_power_high_fast_alarm_reg | tx_power_low_fast_alarm_reg | ceil_reg;
        summary_next = nonmask
            | (|(slow_alarm_img & slow_alarm_enable_i & alarm_status_pkg::SLOW_ALARM_MASK))
            | (|(fast_alarm_img & fast_alarm_enable_i & alarm_status_pkg::FAST_ALARM_MASK))
            | (|(rx_bias_img & rx_bias_enable_i & alarm_status_pkg::RX_BIAS_MASK))
            | (|(warn_img & warn_enable_i & alarm_status_pkg::WARN_MASK))
            | (|(other_flags_i & other_enable_i));
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            summary_reg <= 1'b0;
        end else begin
            summary_reg <= summary_next;
        end
    end

    assign tx_fault_irq_summary_o = summary_reg;

    // ****************************************************************
    // Read port
    // ****************************************************************
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic       rd_valid_reg;
    logic       rd_valid_next;

    // Writes have no path into any image; unmapped reads return zero
    always_comb begin
        rd_valid_next = rd_en_i;
        rd_data_next  = rd_data_reg;
        if (rd_en_i) begin
            unique case (addr_i)
                alarm_status_pkg::SLOW_ALARM_ADDR: rd_data_next = slow_alarm_img;
                alarm_status_pkg::FAST_ALARM_ADDR: rd_data_next = fast_alarm_img;
                alarm_status_pkg::RX_BIAS_ADDR:    rd_data_next = rx_bias_img;
                alarm_status_pkg::WARN_ADDR:       rd_data_next = warn_img;
                default:                           rd_data_next = alarm_status_pkg::ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rd_data_reg  <= alarm_status_pkg::ZERO_BYTE;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign rd_data_o  = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_slow_hi_set: assert property (
        meas_done_i[alarm_status_pkg::MONITOR_INPUT_3_IDX] && tx_disable
        && meas_value_i[alarm_status_pkg::MONITOR_INPUT_3_IDX] > hi_thr_i[alarm_status_pkg::MONITOR_INPUT_3_IDX]
        |=> slow_alarm_img[7]) else $error("monitor 3 high alarm not set");
    chk_slow_lo_set: assert property (
        meas_done_i[alarm_status_pkg::MONITOR_INPUT_4_IDX]
        && meas_value_i[alarm_status_pkg::MONITOR_INPUT_4_IDX] < lo_thr_i[alarm_status_pkg::MONITOR_INPUT_4_IDX]
        |=> slow_alarm_img[4] ##1 (slow_alarm_img[4] || $past(meas_done_i[5])))
        else $error("monitor 4 low alarm not set or lost");
    chk_summary_nonmask: assert property (
        high_bias_fast_alarm_reg || ceil_reg |=> tx_fault_irq_summary_o) else $error("nonmaskable alarm missed");
    chk_txd_clear: assert property (
        tx_disable |=> !high_bias_fast_alarm_reg && !tx_power_high_fast_alarm_reg && !tx_power_low_fast_alarm_reg && !ceil_reg)
        else $error("transmit-side alarm survived disable");
    chk_high_bias_fast_alarm_set: assert property (
        !tx_disable && fast_sample_i && bias_high_cmp_i |=> fast_alarm_img[3])
        else $error("high bias alarm not set");
    chk_txp_follow: assert property (
        !tx_disable && fast_sample_i |=> tx_power_low_fast_alarm_reg == $past(tx_power_low_cmp_i)
        && tx_power_high_fast_alarm_reg == $past(tx_power_high_cmp_i)) else $error("transmit power flags wrong");
    chk_rx_keep: assert property (
        tx_disable && !fast_sample_i |=> $stable(rx_bias_img[7:6]))
        else $error("receive level flags changed without sample");
    chk_ceiling_set: assert property (
        !tx_disable && bias_request_i > bias_ceiling_limit_i |=> rx_bias_img[3])
        else $error("bias ceiling flag not set");
    chk_warn_hi: assert property (
        meas_done_i[0] && meas_value_i[0] > hi_thr_i[0] |=> warn_img[7])
        else $error("temperature high warning not set");
    chk_supply_force: assert property (
        power_on_analog_trip_i |=> warn_img[alarm_status_pkg::SUPPLY_LO_BIT]
        ##1 (warn_img[alarm_status_pkg::SUPPLY_LO_BIT]
        || $past(meas_done_i[alarm_status_pkg::SUPPLY_IDX])))
        else $error("supply low warning not forced");
    chk_reserved_zero: assert property (
        rd_en_i && addr_i == alarm_status_pkg::FAST_ALARM_ADDR
        |=> rd_valid_o && (rd_data_o & ~alarm_status_pkg::FAST_ALARM_MASK) == 8'h00)
        else $error("reserved bits read nonzero");
    chk_soft_disable: assert property (
        tx_disable_soft_bit_i && !tx_disable_pin_i |=> !tx_power_high_fast_alarm_reg)
        else $error("software disable ignored");
    chk_enable_gate: assert property (
        !nonmask && slow_alarm_enable_i == 8'h00 && fast_alarm_enable_i == 8'h00
        && rx_bias_enable_i == 8'h00 && warn_enable_i == 8'h00 && other_enable_i == 16'h0000
        |=> !tx_fault_irq_summary_o) else $error("disabled flag reached summary");

    cov_txd_clears: cover property (high_bias_fast_alarm_reg ##1 tx_disable ##1 !high_bias_fast_alarm_reg);
    cov_summary_warn: cover property (!nonmask && warn_img[7] && warn_enable_i[7]
        ##1 tx_fault_irq_summary_o);
    cov_supply_release: cover property (warn_img[4] ##1 !warn_img[4]);
endmodule // alarm_warning_status_bank

`default_nettype wire

/* test/alarm_warning_status_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module alarm_warning_status_bank_tb;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    localparam int CH = alarm_status_pkg::MEAS_CH;
    localparam int MW = alarm_status_pkg::MEAS_W;
    logic                   clk_i;
    logic                   reset_n_i;
    logic [7:0]             addr_i;
    logic                   rd_en_i;
    logic                   wr_en_i;
    logic [7:0]             wr_data_i;
    logic [7:0]             rd_data_o;
    logic                   rd_valid_o;
    logic [CH-1:0]          meas_done_i;
    logic [CH-1:0][MW-1:0]  meas_value_i;
    logic [CH-1:0][MW-1:0]  hi_thr_i;
    logic [CH-1:0][MW-1:0]  lo_thr_i;
    logic                   power_on_analog_trip_i;
    logic                   fast_sample_i;
    logic [4:0]             cmp_i;
    logic [8:0]             bias_request_i;
    logic [8:0]             bias_ceiling_limit_i;
    logic                   tx_disable_pin_i;
    logic                   tx_disable_soft_bit_i;
    logic [31:0]            en_i;
    logic [15:0]            other_flags_i;
    logic [15:0]            other_enable_i;
    logic                   tx_fault_irq_summary_o;
    logic [7:0]             m71, m72, m73, m74, exp_rd;
    logic                   m_sum, exp_vld, mon_on;
    logic [31:0]            seed;
    int                     error_cnt, total_checks;

    alarm_warning_status_bank u_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .rd_en_i(rd_en_i),
        .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .meas_done_i(meas_done_i), .meas_value_i(meas_value_i),
        .hi_thr_i(hi_thr_i), .lo_thr_i(lo_thr_i),
        .power_on_analog_trip_i(power_on_analog_trip_i), .fast_sample_i(fast_sample_i),
        .bias_high_cmp_i(cmp_i[0]), .tx_power_high_cmp_i(cmp_i[1]),
        .tx_power_low_cmp_i(cmp_i[2]), .rx_level_high_cmp_i(cmp_i[3]),
        .rx_level_low_cmp_i(cmp_i[4]), .bias_request_i(bias_request_i),
        .bias_ceiling_limit_i(bias_ceiling_limit_i), .tx_disable_pin_i(tx_disable_pin_i),
        .tx_disable_soft_bit_i(tx_disable_soft_bit_i), .slow_alarm_enable_i(en_i[31:24]),
        .fast_alarm_enable_i(en_i[23:16]), .rx_bias_enable_i(en_i[15:8]),
        .warn_enable_i(en_i[7:0]), .other_flags_i(other_flags_i),
        .other_enable_i(other_enable_i), .tx_fault_irq_summary_o(tx_fault_irq_summary_o));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Xorshift keeps every run identical for a given seed
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Values cluster on the thresholds so that the equal case is hit often
    function automatic logic [15:0] pick(input int k);
        case (rnd() % 6)
            0: pick = lo_thr_i[k] - 16'h0001;
            1: pick = lo_thr_i[k];
            2: pick = lo_thr_i[k] + 16'h0001;
            3: pick = hi_thr_i[k];
            4: pick = hi_thr_i[k] + 16'h0001;
            default: pick = rnd() >> 16;
        endcase
    endfunction

    function automatic logic [7:0] img(input logic [7:0] ad);
        case (ad)
            alarm_status_pkg::SLOW_ALARM_ADDR: img = {m71[7:4], 3'b000, m_sum};
            alarm_status_pkg::FAST_ALARM_ADDR: img = m72;
            alarm_status_pkg::RX_BIAS_ADDR:    img = m73;
            alarm_status_pkg::WARN_ADDR:       img = m74;
            default:                           img = 8'h00;
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Reference model of the four status registers and the summary
    // ****************************************************************
    always @(posedge clk_i) begin : model
        logic [7:0] a, f, r, w;
        logic       txd;
        if (!reset_n_i) begin
            {m71, m72, m73, exp_rd} <= 32'h0000_0000;
            m74 <= alarm_status_pkg::WARN_RESET;
            m_sum <= 1'b0;
            exp_vld <= 1'b0;
        end else begin
            {a, f, r, w} = {m71, m72, m73, m74};
            txd = tx_disable_pin_i | tx_disable_soft_bit_i;
            for (int k = 0; k < CH; k++) begin
                if (meas_done_i[k] && k < 4) begin
                    w[7-2*k] = meas_value_i[k] > hi_thr_i[k];
                    w[6-2*k] = meas_value_i[k] < lo_thr_i[k];
                end else if (meas_done_i[k]) begin
                    a[15-2*k] = meas_value_i[k] > hi_thr_i[k];
                    a[14-2*k] = meas_value_i[k] < lo_thr_i[k];
                end
            end
            if (power_on_analog_trip_i) begin
                w[4] = 1'b1;
            end
            if (fast_sample_i) begin
                {f[0], f[1], f[3]} = cmp_i[2:0];
                {r[6], r[7]} = cmp_i[4:3];
            end
            r[3] = bias_request_i > bias_ceiling_limit_i;
            if (txd) begin
                f = 8'h00;
                r[3] = 1'b0;
            end
            {m71, m72, m73, m74} <= {a, f, r, w};
            // Summary lags the flags by one register stage
            m_sum <= |(m71 & en_i[31:24]) | |(m72 & en_i[23:16]) | |(m73 & en_i[15:8])
                     | |(m74 & en_i[7:0]) | |(other_flags_i & other_enable_i)
                     | m72[3] | m72[1] | m72[0] | m73[3];
            exp_vld <= rd_en_i;
            if (rd_en_i) begin
                exp_rd <= img(addr_i);
            end
        end
    end

    // Outputs are compared mid-cycle, where they have settled
    always @(negedge clk_i) begin
        if (mon_on) begin
            check({7'h00, rd_valid_o}, {7'h00, exp_vld});
            if (exp_vld) check(rd_data_o, exp_rd);
            check({7'h00, tx_fault_irq_summary_o}, {7'h00, m_sum});
        end
    end

    // ****************************************************************
    // Drivers
    // ****************************************************************
    // One random cycle; mode 0 rare disables, 1 pin held, 2 soft bit held
    task automatic drive(input int mode, input logic trip);
        logic [31:0] r;
        @(posedge clk_i);
        #1;
        r = rnd();
        {rd_en_i, wr_en_i, fast_sample_i, cmp_i} = r[7:0];
        addr_i = 8'h70 + 8'(r[31:8] % 7);
        wr_data_i = r[23:16];
        meas_done_i = CH'(rnd());
        for (int k = 0; k < CH; k++) meas_value_i[k] = pick(k);
        bias_ceiling_limit_i = 9'(rnd());
        bias_request_i = bias_ceiling_limit_i + 9'(rnd() % 3) - 9'h001;
        tx_disable_pin_i = (mode == 1) || (mode == 0 && rnd() % 40 == 0);
        tx_disable_soft_bit_i = (mode == 2) || (mode == 0 && rnd() % 40 == 0);
        power_on_analog_trip_i = trip;
        en_i = rnd() & rnd();
        other_flags_i = 16'(rnd() & rnd() & rnd());
        other_enable_i = 16'(rnd());
    endtask

    // Quiet inputs, then each status register must show its reset value
    task automatic reset_vals;
        @(posedge clk_i);
        #1;
        {meas_done_i, fast_sample_i, wr_en_i, power_on_analog_trip_i} = 9'h000;
        {tx_disable_pin_i, tx_disable_soft_bit_i, other_flags_i} = 18'h00000;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            #1;
            rd_en_i = 1'b1;
            addr_i = alarm_status_pkg::SLOW_ALARM_ADDR + 8'(i);
            @(posedge clk_i);
            #1;
            rd_en_i = 1'b0;
            @(negedge clk_i);
            check(rd_data_o, (i == 3) ? alarm_status_pkg::WARN_RESET : 8'h00);
        end
        $display("Test reset values done");
    endtask

    // ****************************************************************
    // Clock, watchdog and test sequence
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        #80000;
        error_cnt++;
        $display("ERROR at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        seed = 32'h0000_0042;
        {error_cnt, total_checks, mon_on} = '0;
        {reset_n_i, addr_i, rd_en_i, wr_en_i, wr_data_i, meas_done_i} = '0;
        {meas_value_i, power_on_analog_trip_i, fast_sample_i, cmp_i} = '0;
        {bias_request_i, bias_ceiling_limit_i, tx_disable_pin_i} = '0;
        {tx_disable_soft_bit_i, en_i, other_flags_i, other_enable_i} = '0;
        for (int k = 0; k < CH; k++) begin
            hi_thr_i[k] = 16'h8000 + 16'(rnd() % 256);
            lo_thr_i[k] = 16'h4000 + 16'(rnd() % 256);
        end
        repeat (12) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        mon_on = 1'b1;
        reset_vals();
        repeat (3000) drive(0, 1'b0);
        $display("Test random traffic done");
        repeat (300) drive(1, 1'b0);
        repeat (300) drive(2, 1'b0);
        $display("Test transmit disable sources done");
        repeat (300) drive(0, 1'b1);
        repeat (300) drive(0, 1'b0);
        $display("Test supply trip done");
        // A second reset in mid-run must restore the power-on image
        @(posedge clk_i);
        #1;
        reset_n_i = 1'b0;
        // Quiet the strobes, disables, bias request, enables and flag sources first, or stale samples land at the release edge
        {meas_done_i, fast_sample_i, rd_en_i, wr_en_i, power_on_analog_trip_i} = 10'h000;
        {tx_disable_pin_i, tx_disable_soft_bit_i, bias_request_i} = 11'h000;
        {en_i, other_flags_i} = 48'h0000_0000_0000;
        repeat (2) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        reset_vals();
        finish_test();
    end
endmodule // alarm_warning_status_bank_tb

`default_nettype wire
